/* can_pkg.sv */
package can_pkg;

	localparam logic [11:0] CAN_CTRL_OFS    = 12'h000;
	localparam logic [11:0] CAN_ENABLE_OFS  = 12'h004;
	localparam logic [11:0] CAN_FLAGS_OFS   = 12'h008;
	localparam logic [11:0] CAN_SCALE_OFS   = 12'h00C;
	localparam logic [11:0] CAN_LOWLIM_OFS  = 12'h010;
	localparam logic [11:0] CAN_HOTTH_OFS   = 12'h014;
	localparam logic [11:0] CAN_COLDTH_OFS  = 12'h018;
	localparam logic [11:0] CAN_COUNT_OFS   = 12'h01C;
	localparam logic [11:0] CAN_RATIO_OFS   = 12'h020;
	localparam logic [11:0] CAN_IRQST_OFS   = 12'h024;
	localparam logic [11:0] CAN_IRQMSK_OFS  = 12'h028;
	localparam logic [11:0] CAN_STATUS_OFS  = 12'h02C;

	// control register fields
	localparam int CAN_CTRL_COUNT_EN_BIT = 0;
	localparam int CAN_CTRL_HOLD_BIT     = 1;

	// flag, enable and irq layout
	localparam int CAN_HOT_BIT     = 0;
	localparam int CAN_COLD_BIT    = 1;
	localparam int CAN_CNTLOW_BIT  = 2;
	localparam int CAN_SUSP_BIT    = 3;
	localparam int CAN_NFLAGS      = 4;

	// status register fields
	localparam int CAN_ST_ALERT_BIT   = 0;
	localparam int CAN_ST_CHG_EN_BIT  = 1;
	localparam int CAN_ST_EQ_BIT      = 2;
	localparam int CAN_ST_PWR_BIT     = 3;
	localparam int CAN_ST_CHEM_LSB    = 4;

	localparam int CAN_REG_W = 16;

	localparam logic [15:0] CAN_CTRL_RST  = 16'h0000;
	localparam logic [15:0] CAN_ZERO16    = 16'h0000;
	localparam logic [15:0] CAN_SCALE_RST = 16'h0001;
	localparam logic [6:0]  CAN_ARA_ADDR  = 7'h68; // arbitrary value
	localparam logic [1:0]  CAN_STRAP_FILL = 2'h2;

	typedef enum logic [1:0] {
		CAN_CHEM_LI_ION,
		CAN_CHEM_LIFEPO,
		CAN_CHEM_LEAD_FIXED,
		CAN_CHEM_LEAD_PROG
	} can_chem_e;

	typedef struct packed {
		logic [CAN_NFLAGS-1:0] bits;
	} can_flags_s;

endpackage

/* can_alert_notifier.sv */
// Summary of operation
// - counting on, count below low limit and enabled: latch count_low_flag, pull alert.
// - on alert response answer own address and release the alert line in the same cycle.
// - latched flags stay readable in limit_flag_status after the alert response.
// - a flag stays set until software writes zero to that bit only.
// - ratio below hot_threshold with hot_alert_enable sets hot_flag and pulls alert.
// - ratio above cold_threshold with enable sets cold_flag, new alert only while cold_flag was clear.
// - clearing an enable bit stops alerts from that source.
// - coulomb counter runs only while charge_count_enable; count is presettable anytime.
// - count_scale sets prescale between charge ticks and count steps.
// - charger_hold high keeps charger disabled; zero re-enables charging.
// - equalize_request_pin starts an equalization charge for lead-acid batteries.
// - charge algorithm chosen from the two strapped chemistry pins.
// - registers are 16 bits wide; control and flag bits are active high.
// - input power loss with suspend alert enabled sets suspend flag, pulls alert.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module can_alert_notifier
	import can_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        charge_tick,
	input  wire logic        charge_discharging,
	input  wire logic        ratio_valid,
	input  wire logic [15:0] ratio_value,
	input  wire logic        input_power_good,
	input  wire logic        equalize_request_pin,
	input  wire logic        chemistry_select_hi,
	input  wire logic        chemistry_select_lo,
	input  wire logic        ara_request,
	output logic             ara_ack,
	output logic [6:0]       ara_addr,
	output logic             alert_out,
	output logic             alert_oe,
	output logic             charger_enable,
	output logic             equalize_start,
	output logic [1:0]       chemistry_mode,
	output logic             irq
);

	typedef struct packed {
		logic [15:0] ctrl;
		can_flags_s  enable;
		can_flags_s  flags;
		can_flags_s  pending;
		can_flags_s  irq_st;
		can_flags_s  irq_msk;
		logic [15:0] scale;
		logic [15:0] low_limit;
		logic [15:0] hot_th;
		logic [15:0] cold_th;
		logic [15:0] count;
		logic [15:0] prescale;
		logic        count_new;
		logic [15:0] ratio;
		logic        ratio_new;
		logic [1:0]  pwr_sync;
		logic        pwr_prev;
		logic [1:0]  eq_sync;
		logic        eq_prev;
		logic [1:0]  chem_hi_sync;
		logic [1:0]  chem_lo_sync;
		logic        chem_taken;
		logic [1:0]  strap_age;
		can_chem_e   chem;
		logic        equalize_active;
		logic        equalize_start;
		logic        alert_low;
		logic        ara_ack;
		logic [6:0]  ara_addr;
		logic        alert_drive;
		logic        charger_enable;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq;
	} can_state_s;

	can_state_s st_r;
	can_state_s st_nxt;

	logic [15:0]           wdata;
	logic                  setup;
	logic                  wr;
	logic                  mapped;
	logic [15:0]           rdata;
	logic [CAN_NFLAGS-1:0] cond;
	logic [CAN_NFLAGS-1:0] event_set;
	logic [CAN_NFLAGS-1:0] new_flag;
	logic                  wr_ctrl;
	logic                  wr_enable;
	logic                  wr_flags;
	logic                  wr_scale;
	logic                  wr_lowlim;
	logic                  wr_hotth;
	logic                  wr_coldth;
	logic                  wr_count;
	logic                  wr_irqst;
	logic                  wr_irqmsk;

	assign wdata = pwdata[15:0];
	assign setup = psel & ~penable & ~st_r.pready;
	assign wr    = psel & penable & pwrite & st_r.pready;

	// one strobe per writable register; unmapped and read-only offsets hit none
	always_comb begin
		wr_ctrl   = wr & (paddr == CAN_CTRL_OFS);
		wr_enable = wr & (paddr == CAN_ENABLE_OFS);
		wr_flags  = wr & (paddr == CAN_FLAGS_OFS);
		wr_scale  = wr & (paddr == CAN_SCALE_OFS);
		wr_lowlim = wr & (paddr == CAN_LOWLIM_OFS);
		wr_hotth  = wr & (paddr == CAN_HOTTH_OFS);
		wr_coldth = wr & (paddr == CAN_COLDTH_OFS);
		wr_count  = wr & (paddr == CAN_COUNT_OFS);
		wr_irqst  = wr & (paddr == CAN_IRQST_OFS);
		wr_irqmsk = wr & (paddr == CAN_IRQMSK_OFS);
	end

	always_comb begin
		mapped = 1'b1;
		rdata  = CAN_ZERO16;
		unique case (paddr)
			CAN_CTRL_OFS:   rdata = st_r.ctrl;
			CAN_ENABLE_OFS: rdata = {12'h000, st_r.enable.bits};
			CAN_FLAGS_OFS:  rdata = {12'h000, st_r.flags.bits};
			CAN_SCALE_OFS:  rdata = st_r.scale;
			CAN_LOWLIM_OFS: rdata = st_r.low_limit;
			CAN_HOTTH_OFS:  rdata = st_r.hot_th;
			CAN_COLDTH_OFS: rdata = st_r.cold_th;
			CAN_COUNT_OFS:  rdata = st_r.count;
			CAN_RATIO_OFS:  rdata = st_r.ratio;
			CAN_IRQST_OFS:  rdata = {12'h000, st_r.irq_st.bits};
			CAN_IRQMSK_OFS: rdata = {12'h000, st_r.irq_msk.bits};
			CAN_STATUS_OFS: begin
				rdata[CAN_ST_ALERT_BIT]               = st_r.alert_low;
				rdata[CAN_ST_CHG_EN_BIT]              = st_r.charger_enable;
				rdata[CAN_ST_EQ_BIT]                  = st_r.equalize_active;
				rdata[CAN_ST_PWR_BIT]                 = st_r.pwr_prev;
				rdata[CAN_ST_CHEM_LSB+1:CAN_ST_CHEM_LSB] = st_r.chem;
			end
			default:        mapped = 1'b0;
		endcase
	end

	// limit conditions qualified by a fresh value, suspend by a power-good fall; each masked by its enable
	always_comb begin
		cond = '0;
		cond[CAN_HOT_BIT]    = st_r.ratio_new & (st_r.ratio < st_r.hot_th);
		cond[CAN_COLD_BIT]   = st_r.ratio_new & (st_r.ratio > st_r.cold_th);
		cond[CAN_CNTLOW_BIT] = st_r.count_new & st_r.ctrl[CAN_CTRL_COUNT_EN_BIT]
			& (st_r.count < st_r.low_limit);
		cond[CAN_SUSP_BIT]   = st_r.pwr_prev & ~st_r.pwr_sync[1];
		event_set = cond & st_r.enable.bits;
		new_flag  = event_set & ~st_r.flags.bits;
	end

	always_comb begin
		st_nxt = st_r;

		// pin synchronisers; first stage feeds only the second
		st_nxt.pwr_sync     = {st_r.pwr_sync[0], input_power_good};
		st_nxt.pwr_prev     = st_r.pwr_sync[1];
		st_nxt.eq_sync      = {st_r.eq_sync[0], equalize_request_pin};
		st_nxt.eq_prev      = st_r.eq_sync[1];
		st_nxt.chem_hi_sync = {st_r.chem_hi_sync[0], chemistry_select_hi};
		st_nxt.chem_lo_sync = {st_r.chem_lo_sync[0], chemistry_select_lo};

		// straps are caught once, after the synchronisers have filled;
		// a later change of a strap is ignored until the next reset
		if (!st_r.chem_taken) begin
			st_nxt.strap_age = st_r.strap_age + 2'h1;
		end
		if (!st_r.chem_taken && st_r.strap_age == CAN_STRAP_FILL) begin
			st_nxt.chem_taken = 1'b1;
			st_nxt.chem = can_chem_e'({st_r.chem_hi_sync[1], st_r.chem_lo_sync[1]});
		end

		// telemetry capture
		st_nxt.ratio_new = ratio_valid;
		if (ratio_valid) begin
			st_nxt.ratio = ratio_value;
		end

		// coulomb counter with prescale
		st_nxt.count_new = 1'b0;
		if (st_r.ctrl[CAN_CTRL_COUNT_EN_BIT] && charge_tick) begin
			if (st_r.prescale + 16'h0001 >= st_r.scale) begin
				st_nxt.prescale  = CAN_ZERO16;
				st_nxt.count_new = 1'b1;
				st_nxt.count     = charge_discharging ? st_r.count - 16'h0001
					: st_r.count + 16'h0001;
			end else begin
				st_nxt.prescale = st_r.prescale + 16'h0001;
			end
		end

		// register writes
		st_nxt.equalize_start = 1'b0;
		if (wr_ctrl) begin
			st_nxt.ctrl = wdata;
		end
		if (wr_enable) begin
			st_nxt.enable.bits = wdata[CAN_NFLAGS-1:0];
		end
		if (wr_scale) begin
			st_nxt.scale = wdata;
		end
		if (wr_lowlim) begin
			st_nxt.low_limit = wdata;
		end
		if (wr_hotth) begin
			st_nxt.hot_th = wdata;
		end
		if (wr_coldth) begin
			st_nxt.cold_th = wdata;
		end
		if (wr_count) begin
			st_nxt.count    = wdata;
			st_nxt.prescale = CAN_ZERO16;
		end
		if (wr_irqmsk) begin
			st_nxt.irq_msk.bits = wdata[CAN_NFLAGS-1:0];
		end

		// per source: flag clears on a written zero, irq status on a written one;
		// a set in the same cycle wins over either clear
		for (int i = 0; i < CAN_NFLAGS; i++) begin
			if (wr_flags && !wdata[i]) begin
				st_nxt.flags.bits[i] = 1'b0;
			end
			if (wr_irqst && wdata[i]) begin
				st_nxt.irq_st.bits[i] = 1'b0;
			end
			if (ara_request && st_r.alert_low) begin
				st_nxt.pending.bits[i] = 1'b0;
			end
			if (event_set[i]) begin
				st_nxt.flags.bits[i]  = 1'b1;
				st_nxt.irq_st.bits[i] = 1'b1;
			end
			// only a newly latched flag raises the alert again
			if (new_flag[i]) begin
				st_nxt.pending.bits[i] = 1'b1;
			end
			if (!st_nxt.enable.bits[i]) begin
				st_nxt.pending.bits[i] = 1'b0;
			end
		end
		st_nxt.irq       = |(st_nxt.irq_st.bits & st_nxt.irq_msk.bits);
		st_nxt.alert_low = |st_nxt.pending.bits;
		st_nxt.ara_ack   = ara_request & st_r.alert_low;

		// constant outputs still leave from flops so every pin is registered
		st_nxt.ara_addr    = CAN_ARA_ADDR;
		st_nxt.alert_drive = 1'b0;

		// charger control
		st_nxt.charger_enable = ~st_nxt.ctrl[CAN_CTRL_HOLD_BIT] & st_r.pwr_sync[1];
		if (st_r.eq_sync[1] && !st_r.eq_prev && st_r.chem_taken
			&& (st_r.chem == CAN_CHEM_LEAD_FIXED || st_r.chem == CAN_CHEM_LEAD_PROG)) begin
			st_nxt.equalize_start  = 1'b1;
			st_nxt.equalize_active = 1'b1;
		end
		if (!st_nxt.charger_enable) begin
			st_nxt.equalize_active = 1'b0;
		end

		// apb slave: answer in the cycle after setup
		st_nxt.pready = setup;
		if (setup) begin
			st_nxt.prdata  = pwrite ? 32'h0000_0000 : {16'h0000, rdata};
			st_nxt.pslverr = ~mapped;
		end else begin
			st_nxt.pslverr = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st_r.ctrl            <= CAN_CTRL_RST;
			st_r.enable          <= '0;
			st_r.flags           <= '0;
			st_r.pending         <= '0;
			st_r.irq_st          <= '0;
			st_r.irq_msk         <= '0;
			st_r.scale           <= CAN_SCALE_RST;
			st_r.low_limit       <= CAN_ZERO16;
			st_r.hot_th          <= CAN_ZERO16;
			st_r.cold_th         <= CAN_ZERO16;
			st_r.count           <= CAN_ZERO16;
			st_r.prescale        <= CAN_ZERO16;
			st_r.count_new       <= 1'b0;
			st_r.ratio           <= CAN_ZERO16;
			st_r.ratio_new       <= 1'b0;
			st_r.pwr_sync        <= '0;
			st_r.pwr_prev        <= 1'b0;
			st_r.eq_sync         <= '0;
			st_r.eq_prev         <= 1'b0;
			st_r.chem_hi_sync    <= '0;
			st_r.chem_lo_sync    <= '0;
			st_r.chem_taken      <= 1'b0;
			st_r.strap_age       <= '0;
			st_r.chem            <= CAN_CHEM_LI_ION;
			st_r.equalize_active <= 1'b0;
			st_r.equalize_start  <= 1'b0;
			st_r.alert_low       <= 1'b0;
			st_r.ara_ack         <= 1'b0;
			st_r.ara_addr        <= CAN_ARA_ADDR;
			st_r.alert_drive     <= 1'b0;
			st_r.charger_enable  <= 1'b0;
			st_r.prdata          <= '0;
			st_r.pready          <= 1'b0;
			st_r.pslverr         <= 1'b0;
			st_r.irq             <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata         = st_r.prdata;
	assign pready         = st_r.pready;
	assign pslverr        = st_r.pslverr;
	assign ara_ack        = st_r.ara_ack;
	assign ara_addr       = st_r.ara_addr;
	assign alert_out      = st_r.alert_drive;
	assign alert_oe       = st_r.alert_low;
	assign charger_enable = st_r.charger_enable;
	assign equalize_start = st_r.equalize_start;
	assign chemistry_mode = st_r.chem;
	assign irq            = st_r.irq;

endmodule

`default_nettype wire

/* can_alert_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module can_alert_asserts
	import can_pkg::*;
(
	input wire logic        mclk,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        input_power_good,
	input wire logic        chemistry_select_hi,
	input wire logic        chemistry_select_lo,
	input wire logic        ara_request,
	input wire logic        ara_ack,
	input wire logic [6:0]  ara_addr,
	input wire logic        alert_out,
	input wire logic        alert_oe,
	input wire logic        charger_enable,
	input wire logic        equalize_start,
	input wire logic [1:0]  chemistry_mode
);
	logic [1:0] straps;
	assign straps = {chemistry_select_hi, chemistry_select_lo};
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	sequence ara_seen; ara_request && alert_oe; endsequence
	sequence ara_done; ara_ack && !alert_oe; endsequence
	sequence strap_steady; $stable(straps) [*4]; endsequence
	AST_ARA_RELEASE: assert property (ara_seen |=> ara_done)
		else $error("alert response not served");
	AST_ARA_ADDR: assert property (ara_ack |-> ara_addr == CAN_ARA_ADDR)
		else $error("wrong response address");
	AST_OPEN_DRAIN: assert property (alert_out == 1'b0)
		else $error("alert line driven high");
	AST_APB_ANSWER: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("bus answer timing");
	AST_APB_UPPER: assert property (pready |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	AST_APB_ERR: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_POWER_OFF: assert property (!input_power_good [*3] |=> !charger_enable)
		else $error("charger on without power");
	AST_CHEM_SEL: assert property (strap_steady |=> chemistry_mode == straps)
		else $error("chemistry mode wrong");
	AST_EQ_LEAD: assert property (equalize_start |-> chemistry_mode[1])
		else $error("equalize on lithium");
endmodule
bind can_alert_notifier can_alert_asserts u_chk (.mclk(mclk), .reset(reset), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.input_power_good(input_power_good), .chemistry_select_hi(chemistry_select_hi),
	.chemistry_select_lo(chemistry_select_lo), .ara_request(ara_request), .ara_ack(ara_ack),
	.ara_addr(ara_addr), .alert_out(alert_out), .alert_oe(alert_oe),
	.charger_enable(charger_enable), .equalize_start(equalize_start),
	.chemistry_mode(chemistry_mode));
`default_nettype wire

/* can_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module can_host_model
	import can_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       alert_line,
	input  wire logic       slow,
	input  wire logic       ara_ack,
	input  wire logic [6:0] ara_addr,
	output logic            ara_request,
	output logic      [7:0] served
);
	logic [4:0] wait_r;
	// answers the line after a short or long delay, like a busy host
	always @(posedge mclk) begin
		if (reset) begin
			ara_request <= 1'b0;
			wait_r <= '0;
			served <= '0;
		end else begin
			if (ara_ack && ara_addr == CAN_ARA_ADDR)
				served <= served + 8'h01;
			if (!alert_line && wait_r == (slow ? 5'h0C : 5'h03)) begin
				ara_request <= 1'b1;
				wait_r <= '0;
			end else begin
				ara_request <= 1'b0;
				wait_r <= alert_line ? 5'h00 : wait_r + 5'h01;
			end
		end
	end
endmodule
`default_nettype wire

/* can_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench import can_pkg::*;;
	typedef struct {logic [11:0] a; logic [15:0] r, w, e;} can_row_s;
	logic        mclk, reset, psel, penable, pwrite, pready, pslverr, charge_tick, slow;
	logic        charge_discharging, ratio_valid, input_power_good, equalize_request_pin;
	logic        chemistry_select_hi, chemistry_select_lo, ara_request, ara_ack, alert_out;
	logic        alert_oe, charger_enable, equalize_start, irq, seen;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] ratio_value;
	logic [6:0]  ara_addr;
	logic [1:0]  chemistry_mode;
	logic [7:0]  served;
	wire         alert_line = alert_oe ? alert_out : 1'b1;
	int          err_total, checks_done;
	can_row_s    rows [9] = '{'{CAN_CTRL_OFS, 16'h0000, 16'h0003, 16'h0003},
		'{CAN_ENABLE_OFS, 16'h0000, 16'h000F, 16'h000F}, '{CAN_SCALE_OFS, 16'h0001, 16'h0002, 16'h0002},
		'{CAN_LOWLIM_OFS, 16'h0000, 16'h0004, 16'h0004}, '{CAN_HOTTH_OFS, 16'h0000, 16'h0100, 16'h0100},
		'{CAN_COLDTH_OFS, 16'h0000, 16'h0800, 16'h0800}, '{CAN_COUNT_OFS, 16'h0000, 16'h0005, 16'h0005},
		'{CAN_IRQMSK_OFS, 16'h0000, 16'h000F, 16'h000F}, '{12'h030, 16'h0000, 16'h1234, 16'h0000}};
	can_alert_notifier dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .charge_tick(charge_tick), .charge_discharging(charge_discharging),
		.ratio_valid(ratio_valid), .ratio_value(ratio_value), .input_power_good(input_power_good),
		.equalize_request_pin(equalize_request_pin), .chemistry_select_hi(chemistry_select_hi),
		.chemistry_select_lo(chemistry_select_lo), .ara_request(ara_request), .ara_ack(ara_ack),
		.ara_addr(ara_addr), .alert_out(alert_out), .alert_oe(alert_oe), .irq(irq),
		.charger_enable(charger_enable), .equalize_start(equalize_start),
		.chemistry_mode(chemistry_mode));
	can_host_model host (.mclk(mclk), .reset(reset), .alert_line(alert_line), .slow(slow),
		.ara_ack(ara_ack), .ara_addr(ara_addr), .ara_request(ara_request), .served(served));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task final_report();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
		int n;
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 16'h0000, d};
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			final_report();
		end
		q = prdata;
		seen = pslverr;
		{psel, penable} <= 2'b00;
		@(posedge mclk);
	endtask
	task rd(input logic [11:0] a, input logic [15:0] e);
		apb(1'b0, a, 16'h0000);
		chk($sformatf("reg %h", a), {16'h0000, e}, q);
	endtask
	task ratio(input logic [15:0] v);
		{ratio_valid, ratio_value} <= {1'b1, v};
		@(posedge mclk);
		ratio_valid <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
	// waits until the host has served the alert and the line floats high again
	task freed(input logic [7:0] e);
		for (int n = 0; n < 40 && alert_line !== 1'b1; n++)
			@(posedge mclk);
		if (alert_line !== 1'b1) begin
			err_total++;
			final_report();
		end
		repeat (2) @(posedge mclk);
		chk("served", e, served);
	endtask
	initial begin
		{psel, penable, pwrite, charge_tick, ratio_valid, equalize_request_pin} = '0;
		{paddr, pwdata, ratio_value, err_total, checks_done} = '0;
		{reset, input_power_good, charge_discharging, chemistry_select_hi, chemistry_select_lo} = 5'h1E;
		slow = 1'b1;
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		for (int i = 0; i < 9; i++) begin
			rd(rows[i].a, rows[i].r);
			apb(1'b1, rows[i].a, rows[i].w);
			rd(rows[i].a, rows[i].e);
			chk("pslverr", rows[i].a == 12'h030, seen);
		end
		apb(1'b1, CAN_CTRL_OFS, 16'h0001);
		$display("registers done");
		ratio(16'h0080);
		chk("line", 0, alert_line);
		chk("irq", 1, irq);
		freed(8'h01);
		rd(CAN_FLAGS_OFS, 16'h0001);
		slow <= 1'b0;
		ratio(16'h0080);
		chk("line", 1, alert_line);
		ratio(16'h0900);
		chk("line", 0, alert_line);
		freed(8'h02);
		apb(1'b1, CAN_FLAGS_OFS, 16'h0002);
		rd(CAN_FLAGS_OFS, 16'h0002);
		rd(CAN_IRQST_OFS, 16'h0003);
		apb(1'b1, CAN_IRQMSK_OFS, 16'h0000);
		chk("irq", 0, irq);
		apb(1'b1, CAN_IRQST_OFS, 16'h000F);
		rd(CAN_IRQST_OFS, 16'h0000);
		apb(1'b1, CAN_IRQMSK_OFS, 16'h000F);
		chk("irq", 0, irq);
		$display("temperature done");
		apb(1'b1, CAN_ENABLE_OFS, 16'h000C);
		ratio(16'h0080);
		chk("line", 1, alert_line);
		rd(CAN_FLAGS_OFS, 16'h0002);
		for (int k = 0; k < 8; k++) begin
			if (k == 4)
				freed(8'h03);
			if (k == 4)
				apb(1'b1, CAN_CTRL_OFS, 16'h0000);
			charge_tick <= 1'b1;
			@(posedge mclk);
			charge_tick <= 1'b0;
			repeat (3) @(posedge mclk);
		end
		rd(CAN_COUNT_OFS, 16'h0003);
		rd(CAN_FLAGS_OFS, 16'h0006);
		$display("count done");
		chk("charger", 1, charger_enable);
		input_power_good <= 1'b0;
		repeat (6) @(posedge mclk);
		chk("charger", 0, charger_enable);
		freed(8'h04);
		rd(CAN_FLAGS_OFS, 16'h000E);
		input_power_good <= 1'b1;
		apb(1'b1, CAN_CTRL_OFS, 16'h0002);
		repeat (4) @(posedge mclk);
		chk("charger", 0, charger_enable);
		apb(1'b1, CAN_CTRL_OFS, 16'h0000);
		repeat (4) @(posedge mclk);
		chk("charger", 1, charger_enable);
		$display("power done");
		chk("chem", 2'b10, chemistry_mode);
		equalize_request_pin <= 1'b1;
		seen = 1'b0;
		for (int n = 0; n < 10; n++) begin
			@(posedge mclk);
			seen |= (equalize_start === 1'b1);
		end
		chk("equalize", 1, seen);
		$display("equalize done");
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		chk("irq", 0, irq);
		chk("alert", 1, alert_line);
		rd(CAN_FLAGS_OFS, 16'h0000);
		rd(CAN_CTRL_OFS, 16'h0000);
		repeat (6) @(posedge mclk);
		chk("chem", 2'b10, chemistry_mode);
		$display("reset done");
		final_report();
	end
endmodule
`default_nettype wire
